//--- common/pcr_pkg.sv
// Package: register map, field layout, reset values and timing for the power register group
package pcr_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_ON_EVENT = 8'h00;
  localparam logic [7:0] ADDR_CHARGER_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_BATTERY_LOW_ALARM = 8'h04;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int POS_ACK = 4;
  localparam int POS_CAUSE_BATT = 3;
  localparam int POS_CAUSE_BUTTON = 2;
  localparam int POS_CAUSE_ADAPTER = 1;
  localparam int POS_CAUSE_USB = 0;
  localparam int POS_TERM_LO = 6;
  localparam int POS_CURR_LO = 2;
  localparam int POS_CHG_EN = 1;
  localparam int POS_EOC = 0;
  // ------------------------------------------------------------
  // Reset values and field limits
  // ------------------------------------------------------------
  localparam logic [1:0] RST_TERM = 2'h1;
  localparam logic [3:0] RST_CURR_DEFAULT = 4'h4;
  localparam logic [4:0] RST_LOW_STD = 5'h0c;
  localparam logic [4:0] RST_LOW_ALT = 5'h1f;
  localparam logic [4:0] LOW_CODE_SAT = 5'h14;
  localparam logic [1:0] TERM_RESERVED = 2'h3;
  localparam logic [3:0] CURR_MAX = 4'h9;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int ACK_DEADLINE_MS = 128;
  localparam int OFF_DELAY_MS = 2;
  localparam int ACK_DEADLINE_CYC = ACK_DEADLINE_MS * (CLK_HZ / 1000);
  localparam int OFF_DELAY_CYC = OFF_DELAY_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 24;
  typedef enum logic [1:0] {ST_STANDBY, ST_WAIT_ACK, ST_ACTIVE, ST_RESET_DELAY} pcr_state_t;
endpackage

//--- common/pcr_sync_if.sv
// Interface: raw pin levels in, synchronised levels out
interface pcr_sync_if;
  logic [4:0] raw;
  logic [4:0] synced;
  modport src(output raw, input synced);
  modport syn(input raw, output synced);
endinterface

//--- logic/pcr_regs.sv
// Power-on event, charger control and battery-low registers with power sequencing
// Contract
// - Battery-low code, five bits; 0x00 means 3.50/3.70 V, 50 mV steps down, 0x14+ saturate.
// - Battery-low at 0x04 resets to 0x0c, or 0x1f in alternate variant; top bits reserved.
// - Power acknowledge bit 4 resets 0; writing 0 powers down to standby.
// - Power-on event at 0x00 holds read-only cause flags for battery, button, adapter, USB.
// - Charger bits 7:6 select termination voltage, 11 reserved, reset 01.
// - Charger bits 5:2 select 100 to 1000 mA current; reset is factory value.
// - Charger at 0x01: bit 1 enables charger, bit 0 selects end-of-charge; both reset 1.
// - Clearing acknowledge with USB or adapter present does not power down.
// - Acknowledge due within 128 ms; else reset output drops, supplies off 2 ms later.
module pcr_regs #(
  parameter logic alternate_variant = 1'b0,
  parameter logic [3:0] factory_current = pcr_pkg::RST_CURR_DEFAULT,
  parameter int ack_deadline_cyc = pcr_pkg::ACK_DEADLINE_CYC,
  parameter int off_delay_cyc = pcr_pkg::OFF_DELAY_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_addr_hit,
  input wire logic push_button_input,
  input wire logic adapter_supply_input,
  input wire logic usb_supply_input,
  input wire logic battery_insert_input,
  input wire logic power_acknowledge_pin,
  output logic system_reset_output,
  output logic supplies_enable,
  output logic charger_enable,
  output logic [1:0] termination_voltage,
  output logic [3:0] full_rate_current_field,
  output logic end_of_charge_select,
  output logic [4:0] battery_low_alarm_level
);
  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  pcr_sync_if pins();
  assign pins.raw = {power_acknowledge_pin, battery_insert_input, push_button_input,
                     adapter_supply_input, usb_supply_input};
  pcr_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .sig(pins)
  );
  logic usb_s, adapter_s, button_s, batt_s, ack_pin_s, ext_supply;
  assign usb_s = pins.synced[0];
  assign adapter_s = pins.synced[1];
  assign button_s = pins.synced[2];
  assign batt_s = pins.synced[3];
  assign ack_pin_s = pins.synced[4];
  assign ext_supply = usb_s | adapter_s;

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] off);
    wr_at = reg_wr && (a == off);
  endfunction

  function automatic logic rose_now(input logic cur, input logic prev);
    rose_now = cur & ~prev;
  endfunction

  // ------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------
  pcr_pkg::pcr_state_t state_ff, nxt_state;
  logic ack_ff;
  logic [3:0] cause_ff;
  logic [1:0] term_ff;
  logic [3:0] curr_ff;
  logic chg_en_ff, eoc_ff;
  logic [4:0] low_ff;
  logic [pcr_pkg::CNT_W-1:0] cnt_ff;
  logic btn_prev_ff, batt_prev_ff;
  logic usb_prev_ff, adp_prev_ff;
  logic acked, power_event;

  assign acked = ack_ff | ack_pin_s;
  // Supplies count only as they appear, so a charger left in after a missed acknowledge
  // parks in standby instead of cycling power
  assign power_event = rose_now(button_s, btn_prev_ff) | rose_now(batt_s, batt_prev_ff) |
                       rose_now(adapter_s, adp_prev_ff) | rose_now(usb_s, usb_prev_ff);

  // Acknowledge bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else if (wr_at(reg_addr, pcr_pkg::ADDR_POWER_ON_EVENT)) begin
      ack_ff <= reg_wdata[pcr_pkg::POS_ACK];
    end else if (state_ff == pcr_pkg::ST_STANDBY) begin
      ack_ff <= 1'b0;
    end
  end

  // Cause flags; captured when leaving standby, writes leave them alone
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cause_ff <= 4'h0;
      btn_prev_ff <= 1'b0;
      batt_prev_ff <= 1'b0;
      usb_prev_ff <= 1'b0;
      adp_prev_ff <= 1'b0;
    end else begin
      btn_prev_ff <= button_s;
      batt_prev_ff <= batt_s;
      usb_prev_ff <= usb_s;
      adp_prev_ff <= adapter_s;
      if (state_ff == pcr_pkg::ST_STANDBY && power_event) begin
        cause_ff <= {rose_now(batt_s, batt_prev_ff), rose_now(button_s, btn_prev_ff),
                     rose_now(adapter_s, adp_prev_ff), rose_now(usb_s, usb_prev_ff)};
      end
    end
  end

  // Charger control
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      term_ff <= pcr_pkg::RST_TERM;
      curr_ff <= factory_current;
      chg_en_ff <= 1'b1;
      eoc_ff <= 1'b1;
    end else if (wr_at(reg_addr, pcr_pkg::ADDR_CHARGER_CONTROL)) begin
      term_ff <= reg_wdata[pcr_pkg::POS_TERM_LO +: 2];
      curr_ff <= reg_wdata[pcr_pkg::POS_CURR_LO +: 4];
      chg_en_ff <= reg_wdata[pcr_pkg::POS_CHG_EN];
      eoc_ff <= reg_wdata[pcr_pkg::POS_EOC];
    end
  end

  // Battery-low threshold code
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      low_ff <= alternate_variant ? pcr_pkg::RST_LOW_ALT : pcr_pkg::RST_LOW_STD;
    end else if (wr_at(reg_addr, pcr_pkg::ADDR_BATTERY_LOW_ALARM)) begin
      low_ff <= reg_wdata[4:0];
    end
  end

  // ------------------------------------------------------------
  // Power sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pcr_pkg::ST_STANDBY: begin
        if (power_event) begin
          nxt_state = pcr_pkg::ST_WAIT_ACK;
        end
      end
      pcr_pkg::ST_WAIT_ACK: begin
        if (acked) begin
          nxt_state = pcr_pkg::ST_ACTIVE;
        end else if (cnt_ff == pcr_pkg::CNT_W'(ack_deadline_cyc - 1)) begin
          nxt_state = pcr_pkg::ST_RESET_DELAY;
        end
      end
      pcr_pkg::ST_ACTIVE: begin
        if (!acked && !ext_supply) begin
          nxt_state = pcr_pkg::ST_STANDBY;
        end
      end
      pcr_pkg::ST_RESET_DELAY: begin
        if (cnt_ff == pcr_pkg::CNT_W'(off_delay_cyc - 1)) begin
          nxt_state = pcr_pkg::ST_STANDBY;
        end
      end
      default: nxt_state = pcr_pkg::ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff <= pcr_pkg::ST_STANDBY;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + pcr_pkg::CNT_W'(1);
      end
    end
  end

  // Outputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      system_reset_output <= 1'b0;
      supplies_enable <= 1'b0;
    end else begin
      system_reset_output <= (nxt_state == pcr_pkg::ST_WAIT_ACK) ||
                             (nxt_state == pcr_pkg::ST_ACTIVE);
      supplies_enable <= (nxt_state != pcr_pkg::ST_STANDBY);
    end
  end

  assign charger_enable = chg_en_ff;
  assign end_of_charge_select = eoc_ff;
  assign termination_voltage = term_ff;
  assign full_rate_current_field = curr_ff;
  assign battery_low_alarm_level = low_ff;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    reg_rdata = 8'h00;
    reg_addr_hit = 1'b1;
    case (reg_addr)
      pcr_pkg::ADDR_POWER_ON_EVENT: reg_rdata = {3'h0, ack_ff, cause_ff};
      pcr_pkg::ADDR_CHARGER_CONTROL: reg_rdata = {term_ff, curr_ff, chg_en_ff, eoc_ff};
      pcr_pkg::ADDR_BATTERY_LOW_ALARM: reg_rdata = {3'h0, low_ff};
      default: reg_addr_hit = 1'b0;
    endcase
    if (!reg_rd) begin
      reg_rdata = 8'h00;
    end
  end
endmodule

//--- logic/pcr_sync.sv
// Two-stage synchroniser for the pin inputs
module pcr_sync (
  input wire logic clk_sys,
  input wire logic reset,
  pcr_sync_if.syn sig
);
  logic [4:0] stage1_ff;
  logic [4:0] stage2_ff;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1_ff <= 5'h00;
      stage2_ff <= 5'h00;
    end else begin
      stage1_ff <= sig.raw;
      stage2_ff <= stage1_ff;
    end
  end
  assign sig.synced = stage2_ff;
endmodule

//--- sim/pcr_host_model.sv
// Host model: drives the power acknowledge pin after the system leaves reset
module pcr_host_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic system_reset_output,
  input wire logic ack_en,
  output logic power_acknowledge_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_ff;
  always_ff @(negedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_ff <= 4'h0;
      power_acknowledge_pin <= 1'b0;
    end else if (!system_reset_output || !ack_en) begin
      wait_ff <= 4'h0;
      power_acknowledge_pin <= 1'b0;
    end else if (wait_ff == 4'h3) begin
      power_acknowledge_pin <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

//--- sim/pcr_regs_monitor.sv
// Checker: register read, write and power sequencing relations
module pcr_regs_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_addr_hit,
  input wire logic usb_supply_input,
  input wire logic system_reset_output,
  input wire logic supplies_enable,
  input wire logic charger_enable,
  input wire logic [1:0] termination_voltage,
  input wire logic [3:0] full_rate_current_field,
  input wire logic end_of_charge_select,
  input wire logic [4:0] battery_low_alarm_level
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_PON_RSVD: assert property (reg_rd && reg_addr == pcr_pkg::ADDR_POWER_ON_EVENT
    |-> reg_rdata[7:5] == 3'h0) else $error("event register reserved bits not zero");
  AST_LOW_READ: assert property (reg_rd && reg_addr == pcr_pkg::ADDR_BATTERY_LOW_ALARM
    |-> reg_rdata == {3'h0, battery_low_alarm_level}) else $error("battery low read wrong");
  AST_CHG_READ: assert property (reg_rd && reg_addr == pcr_pkg::ADDR_CHARGER_CONTROL
    |-> reg_rdata == {termination_voltage, full_rate_current_field, charger_enable,
    end_of_charge_select}) else $error("charger control read wrong");
  AST_CHG_WRITE: assert property (reg_wr && reg_addr == pcr_pkg::ADDR_CHARGER_CONTROL
    && reg_wdata[7:6] != 2'h3 && reg_wdata[5:2] <= 4'h9 |=> {termination_voltage,
    full_rate_current_field, charger_enable, end_of_charge_select} == $past(reg_wdata))
    else $error("charger control write lost");
  AST_LOW_WRITE: assert property (reg_wr && reg_addr == pcr_pkg::ADDR_BATTERY_LOW_ALARM
    |=> battery_low_alarm_level == $past(reg_wdata[4:0])) else $error("battery low write lost");
  AST_UNMAPPED: assert property (reg_rd && !reg_addr_hit |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_OFF_DELAY: assert property ($fell(system_reset_output) && supplies_enable
    |-> supplies_enable [*6] ##[1:8] !supplies_enable) else $error("supplies off delay wrong");
  AST_NO_RST_OFF: assert property (!supplies_enable |-> !system_reset_output)
    else $error("reset released without supplies");
  AST_USB_KEEP: assert property (usb_supply_input [*4] ##0 system_reset_output
    |=> supplies_enable) else $error("powered down with supply present");
endmodule
bind pcr_regs pcr_regs_monitor u_mon (.clk_sys, .reset, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_addr_hit, .usb_supply_input, .system_reset_output,
  .supplies_enable, .charger_enable, .termination_voltage, .full_rate_current_field,
  .end_of_charge_select, .battery_low_alarm_level);

//--- sim/test_pcr_regs.sv
// Testbench: register access and power sequencing scenarios
module test_pcr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, pb = 1'h0, usb = 1'h0;
  logic adp = 1'h0, bat = 1'h0, ack_en = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic hit, srst, sup, ce, eoc, pin;
  logic [1:0] tv;
  logic [3:0] cur;
  logic [4:0] low, low_alt;
  int mismatches = 0, tests_run = 0, n;
  initial forever #50 clk_sys = ~clk_sys;
  pcr_regs #(.ack_deadline_cyc(50), .off_delay_cyc(10)) uut (.clk_sys, .reset, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_addr_hit(hit), .push_button_input(pb),
    .adapter_supply_input(adp), .usb_supply_input(usb), .battery_insert_input(bat),
    .power_acknowledge_pin(pin), .system_reset_output(srst), .supplies_enable(sup),
    .charger_enable(ce), .termination_voltage(tv), .full_rate_current_field(cur),
    .end_of_charge_select(eoc), .battery_low_alarm_level(low));
  pcr_host_model host (.clk_sys, .reset, .system_reset_output(srst), .ack_en,
    .power_acknowledge_pin(pin));
  pcr_regs #(.alternate_variant(1'h1)) uut_alt (.clk_sys, .reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata(), .reg_addr_hit(), .push_button_input(1'h0),
    .adapter_supply_input(1'h0), .usb_supply_input(1'h0), .battery_insert_input(1'h0),
    .power_acknowledge_pin(1'h0), .system_reset_output(), .supplies_enable(),
    .charger_enable(), .termination_voltage(), .full_rate_current_field(),
    .end_of_charge_select(), .battery_low_alarm_level(low_alt));
  task end_sim;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] v);
    @(negedge clk_sys);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr = 0;
  endtask
  task rd(logic [7:0] a);
    @(negedge clk_sys);
    reg_rd = 1;
    reg_addr = a;
    @(posedge clk_sys);
    d = reg_rdata;
    @(negedge clk_sys);
    reg_rd = 0;
  endtask
  task wt(bit sel, logic v);
    for (n = 0; n < 200 && (sel ? srst : sup) !== v; n++) @(negedge clk_sys);
    if (n == 200) begin
      mismatches++;
      end_sim;
    end
  endtask
  task t_reset;
    chk("low alt", {3'h0, low_alt}, 8'h1f);
    rd(8'h00);
    chk("event", d, 8'h00);
    rd(8'h01);
    chk("charger", d, 8'h53);
    rd(8'h04);
    chk("low", d, 8'h0c);
    chk("hit", {7'h0, hit}, 8'h01);
    $display("t_reset done");
  endtask
  task t_regs;
    wr(8'h01, 8'ha6);
    wr(8'h04, 8'hff);
    rd(8'h01);
    chk("charger", d, 8'ha6);
    chk("fields", {tv, cur, ce, eoc}, 8'ha6);
    rd(8'h04);
    chk("low", d, 8'h1f);
    chk("level", {3'h0, low}, 8'h1f);
    wr(8'h00, 8'hef);
    rd(8'h00);
    chk("event", d, 8'h00);
    rd(8'h02);
    chk("unmapped", d | {7'h0, hit}, 8'h00);
    $display("t_regs done");
  endtask
  task t_ack;
    ack_en = 1'h1;
    @(negedge clk_sys) pb = 1'h1;
    wt(1, 1);
    rd(8'h00);
    chk("cause", d, 8'h04);
    wr(8'h00, 8'h10);
    ack_en = 1'h0;
    rd(8'h00);
    chk("ack", d, 8'h14);
    wr(8'h00, 8'h00);
    wt(0, 0);
    chk("standby", {7'h0, srst}, 8'h00);
    $display("t_ack done");
  endtask
  task t_deadline;
    pb = 1'h0;
    @(negedge clk_sys) pb = 1'h1;
    wt(1, 1);
    wt(1, 0);
    chk("deadline", {7'h0, n >= 45 && n <= 55}, 8'h01);
    wt(0, 0);
    chk("off", {7'h0, n >= 8 && n <= 12}, 8'h01);
    $display("t_deadline done");
  endtask
  task t_usb;
    ack_en = 1'h1;
    usb = 1'h1;
    wt(1, 1);
    repeat (8) @(negedge clk_sys);
    rd(8'h00);
    chk("cause", d & 8'h0f, 8'h01);
    ack_en = 1'h0;
    wr(8'h00, 8'h00);
    d = 8'h01;
    repeat (20) begin
      @(negedge clk_sys);
      d = d & {7'h0, sup};
    end
    chk("stay", d, 8'h01);
    usb = 1'h0;
    wt(0, 0);
    $display("t_usb done");
  endtask
  task t_cause;
    bat = 1'h1;
    wt(1, 1);
    rd(8'h00);
    chk("cause", d, 8'h08);
    wt(0, 0);
    bat = 1'h0;
    adp = 1'h1;
    wt(1, 1);
    rd(8'h00);
    chk("cause", d, 8'h02);
    wt(0, 0);
    d = 8'h00;
    repeat (20) begin
      @(negedge clk_sys);
      d = d | {7'h0, sup};
    end
    chk("charger standby", d, 8'h00);
    adp = 1'h0;
    $display("t_cause done");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) reset = 1'h0;
    t_reset;
    t_regs;
    t_ack;
    t_deadline;
    t_usb;
    t_cause;
    end_sim;
  end
endmodule
